//--- rtl/dbs_dma_engine.sv
// Single-channel DMA engine that shares the system bus with the CPU.
// Summary of operation
// - Repeat mode reloads size; only in burst mode does it restart at once, otherwise it waits for a trigger.
// - Burst block gives two of ten cycles to the CPU.
// - Debug halt waits three quiet cycles, CPU idle.
// - Repeat burst keeps bus request continuously asserted.
// - Transfers never clear an already set flag.
`default_nettype none
module dbs_dma_engine
    import dbs_pkg::*;
#(
    parameter int ADDR_W = DBS_ADDR_W,
    parameter int DATA_W = DBS_DATA_W,
    parameter int SIZE_W = DBS_SIZE_W,
    parameter int FIFO_DEPTH = DBS_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic channel_enable_bit,
    input wire logic repeat_mode,
    input wire logic burst_mode,
    input wire logic rmw_transfer_block_bit,
    input wire logic cpu_rmw_active,
    input wire logic [ADDR_W-1:0] channel_source_address,
    input wire logic [ADDR_W-1:0] channel_destination_address,
    input wire logic [SIZE_W-1:0] channel_transfer_size_counter,
    input wire logic dma_trigger,
    input wire logic cpu_bus_req,
    input wire logic debug_halt_req,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic bus_ready,
    input wire logic [DBS_FLAG_W-1:0] periph_flags,
    output logic [ADDR_W-1:0] bus_addr_ff,
    output logic bus_rd_ff,
    output logic bus_wr_ff,
    output logic [DATA_W-1:0] bus_wdata_ff,
    output logic dma_bus_req_ff,
    output logic cpu_slot_ff,
    output logic debug_halt_grant_ff,
    output logic block_done_ff,
    output logic [SIZE_W-1:0] size_left_ff
);
    dbs_state_t state_ff;
    dbs_state_t nxt_state;
    logic [ADDR_W-1:0] src_ff;
    logic [ADDR_W-1:0] dst_ff;
    logic en_d_ff;
    logic pending_ff;
    logic [3:0] slot_ff;
    logic [3:0] nxt_slot;
    logic [1:0] quiet_ff;
    logic may_go;
    logic start_rd;
    logic start_wr;
    logic rd_done;
    logic wr_done;
    logic go;
    logic burst_run;
    logic rearm;
    logic cpu_next;

    dbs_fifo_if #(.WIDTH(DATA_W)) fq ();
    dbs_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .q(fq.fifo)
    );
    function automatic logic [DATA_W-1:0] keep_flags(
        input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] data,
        input logic [DBS_FLAG_W-1:0] flags);
        keep_flags = data;
        if (addr == ADDR_W'(DBS_FLAG_ADDR)) begin
            keep_flags = data | DATA_W'(flags);
        end
    endfunction : keep_flags
    // A CPU slot, the cycle before one, and a held-off RMW pause new cycles.
    assign may_go = !cpu_slot_ff && !cpu_next
                    && !(rmw_transfer_block_bit && cpu_rmw_active);
    assign start_rd = (state_ff == DBS_READ) && !bus_rd_ff && may_go
                      && fq.in_ready;
    assign rd_done = bus_rd_ff && bus_ready;
    assign start_wr = (state_ff == DBS_WRITE) && !bus_wr_ff && may_go
                      && fq.out_valid;
    assign wr_done = bus_wr_ff && bus_ready;
    assign go = channel_enable_bit && (pending_ff || dma_trigger);
    assign burst_run = burst_mode && (state_ff != DBS_IDLE);
    assign rearm = repeat_mode && channel_enable_bit;
    assign fq.in_data = bus_rdata;
    assign fq.in_valid = rd_done;
    assign fq.out_ready = start_wr;
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            DBS_IDLE: begin
                if (go && size_left_ff != DBS_SIZE_ZERO) begin
                    nxt_state = DBS_READ;
                end
            end
            DBS_READ: begin
                if (rd_done) begin
                    nxt_state = DBS_WRITE;
                end
            end
            DBS_WRITE: begin
                if (wr_done) begin
                    if (size_left_ff == DBS_SIZE_ONE) begin
                        nxt_state = DBS_RELOAD;
                    end else if (burst_mode) begin
                        nxt_state = DBS_READ;
                    end else begin
                        nxt_state = DBS_IDLE;
                    end
                end
            end
            DBS_RELOAD: begin
                nxt_state = (rearm && burst_mode) ? DBS_READ : DBS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= DBS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // A trigger landing as a held one is consumed stays pending.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pending_ff <= 1'b0;
        end else if (!channel_enable_bit) begin
            pending_ff <= 1'b0;
        end else if (state_ff == DBS_IDLE && nxt_state == DBS_READ) begin
            pending_ff <= pending_ff && dma_trigger;
        end else if (dma_trigger) begin
            pending_ff <= 1'b1;
        end
    end

    // Addresses and size load on enable and again on a repeat reload.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_d_ff <= 1'b0;
            src_ff <= '0;
            dst_ff <= '0;
            size_left_ff <= '0;
        end else begin
            en_d_ff <= channel_enable_bit;
            if ((channel_enable_bit && !en_d_ff)
                || (state_ff == DBS_RELOAD && rearm)) begin
                src_ff <= channel_source_address;
                dst_ff <= channel_destination_address;
                size_left_ff <= channel_transfer_size_counter;
            end else begin
                if (rd_done) begin
                    src_ff <= src_ff + ADDR_W'(DBS_ADDR_STEP);
                end
                if (wr_done) begin
                    dst_ff <= dst_ff + ADDR_W'(DBS_ADDR_STEP);
                    size_left_ff <= size_left_ff - 1'b1;
                end
            end
        end
    end

    // Bus master cycles; a write to a flag register ORs in set flags.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_rd_ff <= 1'b0;
            bus_wr_ff <= 1'b0;
            bus_addr_ff <= '0;
            bus_wdata_ff <= '0;
        end else begin
            if (start_rd) begin
                bus_rd_ff <= 1'b1;
                bus_addr_ff <= src_ff;
            end else if (rd_done) begin
                bus_rd_ff <= 1'b0;
            end
            if (start_wr) begin
                bus_wr_ff <= 1'b1;
                bus_addr_ff <= dst_ff;
                bus_wdata_ff <= keep_flags(dst_ff, fq.out_data,
                                           periph_flags);
            end else if (wr_done) begin
                bus_wr_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            block_done_ff <= 1'b0;
        end else begin
            block_done_ff <= (state_ff == DBS_RELOAD);
        end
    end

    // Ten-cycle burst frame: slots eight and nine belong to the CPU.
    always_comb begin
        nxt_slot = DBS_SLOT_FIRST;
        if (burst_mode && nxt_state != DBS_IDLE) begin
            nxt_slot = (slot_ff == DBS_SLOT_LAST) ? DBS_SLOT_FIRST
                                                  : slot_ff + 1'b1;
        end
    end
    assign cpu_next = burst_mode && nxt_state != DBS_IDLE
                      && nxt_slot >= DBS_SLOT_CPU_FIRST;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slot_ff <= DBS_SLOT_FIRST;
            cpu_slot_ff <= 1'b0;
        end else begin
            slot_ff <= nxt_slot;
            cpu_slot_ff <= cpu_next;
        end
    end

    // In burst mode the request covers the whole block and every repeat of it; otherwise it drops after each transfer.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dma_bus_req_ff <= 1'b0;
        end else begin
            dma_bus_req_ff <= (nxt_state != DBS_IDLE);
        end
    end

    // Halt is granted only after three cycles without a DMA request.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            quiet_ff <= '0;
            debug_halt_grant_ff <= 1'b0;
        end else begin
            if (dma_bus_req_ff) begin
                quiet_ff <= '0;
            end else if (quiet_ff != DBS_HALT_QUIET) begin
                quiet_ff <= quiet_ff + 1'b1;
            end
            debug_halt_grant_ff <= debug_halt_req && !dma_bus_req_ff
                && quiet_ff == DBS_HALT_QUIET && !cpu_bus_req;
        end
    end

    default clocking dbs_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_cpu_pair;
        cpu_slot_ff ##1 (cpu_slot_ff || !burst_run);
    endsequence
    sequence s_quiet_three;
        !dma_bus_req_ff ##1 !dma_bus_req_ff ##1 !dma_bus_req_ff;
    endsequence
    a_reload_size: assert property (
        state_ff == DBS_RELOAD && rearm
        |=> size_left_ff == $past(channel_transfer_size_counter))
        else $error("Repeat reload lost the size.");
    a_repeat_restart: assert property (
        state_ff == DBS_RELOAD && rearm && burst_mode
        |=> state_ff == DBS_READ)
        else $error("Repeat burst did not restart at once.");
    a_cpu_two_slots: assert property (
        $rose(cpu_slot_ff) |-> s_cpu_pair ##1 !cpu_slot_ff)
        else $error("CPU share is not two cycles.");
    a_cpu_slot_idle: assert property (
        cpu_slot_ff |-> !fq.out_ready && !fq.in_valid)
        else $error("Engine moved data in a CPU slot.");
    a_halt_quiet: assert property (
        s_quiet_three ##1 (debug_halt_req && !cpu_bus_req && !dma_bus_req_ff)
        |=> debug_halt_grant_ff)
        else $error("Halt not granted after quiet bus.");
    a_halt_blocked: assert property (
        (dma_bus_req_ff || cpu_bus_req) |=> !debug_halt_grant_ff)
        else $error("Halt granted while bus requested.");
    a_repeat_hold: assert property (
        state_ff == DBS_RELOAD && rearm && burst_mode
        |=> dma_bus_req_ff [*2])
        else $error("Request dropped in repeat burst.");
    a_flag_kept: assert property (
        $rose(bus_wr_ff) && bus_addr_ff == ADDR_W'(DBS_FLAG_ADDR)
        |-> (bus_wdata_ff & DATA_W'($past(periph_flags)))
            == DATA_W'($past(periph_flags)))
        else $error("Transfer cleared a set flag.");
    a_rmw_hold: assert property (
        rmw_transfer_block_bit && cpu_rmw_active
        |=> !$rose(bus_rd_ff) && !$rose(bus_wr_ff))
        else $error("Transfer broke into a held access.");
endmodule : dbs_dma_engine
`default_nettype wire

//--- rtl/dbs_fifo.sv
// Flip-flop FIFO holding words between the read and write bus phases.
`default_nettype none
module dbs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    dbs_fifo_if.fifo q
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [CW-1:0] cnt_ff;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    assign q.in_ready = (cnt_ff != CNT_FULL);
    assign q.out_valid = (cnt_ff != '0);
    assign q.out_data = mem_ff[rd_ptr_ff];
    assign push = q.in_valid && q.in_ready;
    assign pop = q.out_valid && q.out_ready;

    // Storage is written only on an accepted push.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= q.in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            end
            if (pop) begin
                rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule : dbs_fifo
`default_nettype wire

//--- rtl/dbs_fifo_if.sv
// Valid/ready carrier between the engine and its data FIFO.
`default_nettype none
interface dbs_fifo_if #(parameter int WIDTH = 16);
    logic [WIDTH-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
    logic out_ready;
    modport fifo (input in_data, input in_valid, output in_ready,
                  output out_data, output out_valid, input out_ready);
    modport engine (output in_data, output in_valid, input in_ready,
                    input out_data, input out_valid, output out_ready);
endinterface : dbs_fifo_if
`default_nettype wire

//--- rtl/dbs_pkg.sv
// Shared constants and types of the bus-sharing DMA engine.
`default_nettype none
package dbs_pkg;
    localparam int DBS_ADDR_W = 20;
    localparam int DBS_DATA_W = 16;
    localparam int DBS_SIZE_W = 16;
    localparam int DBS_FLAG_W = 8;
    localparam int DBS_FIFO_DEPTH = 4;
    localparam logic [3:0] DBS_SLOT_LAST = 4'h9;
    localparam logic [3:0] DBS_SLOT_CPU_FIRST = 4'h8;
    localparam logic [3:0] DBS_SLOT_FIRST = 4'h0;
    localparam logic [1:0] DBS_HALT_QUIET = 2'h3;
    localparam logic [19:0] DBS_ADDR_STEP = 20'h00002;
    localparam logic [19:0] DBS_FLAG_ADDR = 20'h00400;
    localparam logic [15:0] DBS_SIZE_ONE = 16'h0001;
    localparam logic [15:0] DBS_SIZE_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        DBS_IDLE = 2'b00,
        DBS_READ = 2'b01,
        DBS_WRITE = 2'b10,
        DBS_RELOAD = 2'b11
    } dbs_state_t;
endpackage : dbs_pkg
`default_nettype wire

//--- test/dbs_bus_model.sv
// Bus memory model with wait states on the engine's far side.
`default_nettype none
module dbs_bus_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [19:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [15:0] bus_wdata,
    input wire logic [3:0] wait_cycles,
    output logic [15:0] bus_rdata,
    output logic bus_ready,
    output logic [19:0] last_addr_ff,
    output logic [15:0] last_data_ff,
    output logic [7:0] wr_count_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_ff;
    logic [15:0] old_ff;
    // Each cycle is stalled wait_cycles cycles before ready, and only one runs at a time.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_ff <= 4'h0;
        end else if (bus_ready || !(bus_rd || bus_wr)) begin
            wait_ff <= 4'h0;
        end else begin
            wait_ff <= wait_ff + 4'h1;
        end
    end
    assign bus_ready = (bus_rd || bus_wr) && (wait_ff >= wait_cycles);
    // Released read data shows the inverse of the last value.
    assign bus_rdata = bus_rd ? (bus_addr[15:0] ^ 16'hA5A5) : ~old_ff;
    always_ff @(posedge ref_clk) begin
        old_ff <= bus_rdata;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_addr_ff <= 20'h00000;
            last_data_ff <= 16'h0000;
            wr_count_ff <= 8'h00;
        end else if (bus_wr && bus_ready) begin
            last_addr_ff <= bus_addr;
            last_data_ff <= bus_wdata;
            wr_count_ff <= wr_count_ff + 8'h01;
        end
    end
endmodule : dbs_bus_model
`default_nettype wire

//--- test/dbs_dma_engine_tb.sv
// Self-checking bench for the bus-sharing DMA engine.
`default_nettype none
module dbs_dma_engine_tb import dbs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, en, rep, bst, blk, rmw, trig, cpu_req, halt;
    logic rd, wr, ready, req, slot, grant, done;
    logic [19:0] src, dst, b_addr, l_addr;
    logic [15:0] size, rdata, wdata, l_data, left;
    logic [7:0] flags, wcnt;
    logic [3:0] waits;
    int bad_count, checks_done, cyc;
    dbs_dma_engine uut (.ref_clk(ref_clk), .rst(rst),
        .channel_enable_bit(en), .repeat_mode(rep), .burst_mode(bst),
        .rmw_transfer_block_bit(blk), .cpu_rmw_active(rmw),
        .channel_source_address(src), .channel_destination_address(dst),
        .channel_transfer_size_counter(size), .dma_trigger(trig),
        .cpu_bus_req(cpu_req), .debug_halt_req(halt), .bus_rdata(rdata),
        .bus_ready(ready), .periph_flags(flags), .bus_addr_ff(b_addr),
        .bus_rd_ff(rd), .bus_wr_ff(wr), .bus_wdata_ff(wdata),
        .dma_bus_req_ff(req), .cpu_slot_ff(slot),
        .debug_halt_grant_ff(grant), .block_done_ff(done),
        .size_left_ff(left));
    dbs_bus_model model (.ref_clk(ref_clk), .rst(rst), .bus_addr(b_addr),
        .bus_rd(rd), .bus_wr(wr), .bus_wdata(wdata), .wait_cycles(waits),
        .bus_rdata(rdata), .bus_ready(ready), .last_addr_ff(l_addr),
        .last_data_ff(l_data), .wr_count_ff(wcnt));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] mem(input logic [19:0] a);
        return a[15:0] ^ 16'hA5A5;
    endfunction : mem
    // Addresses change only with the channel off, below 64K.
    task automatic cfg(input logic r, input logic b, input logic [19:0] s,
        input logic [19:0] d, input logic [15:0] n);
        @(posedge ref_clk);
        en <= 1'b0;
        rep <= r;
        bst <= b;
        src <= s;
        dst <= d;
        size <= n;
        @(posedge ref_clk);
        en <= 1'b1;
    endtask : cfg
    task automatic pulse();
        @(posedge ref_clk);
        trig <= 1'b1;
        @(posedge ref_clk);
        trig <= 1'b0;
    endtask : pulse
    task automatic wait_wr();
        logic [7:0] old;
        int i;
        old = wcnt;
        i = 0;
        while (wcnt === old && i < 100) begin
            @(negedge ref_clk);
            i++;
        end
    endtask : wait_wr
    task automatic wait_done();
        int i;
        i = 0;
        while (done !== 1'b1 && i < 100) begin
            @(negedge ref_clk);
            i++;
        end
    endtask : wait_done
    task automatic t_repeat();
        cfg(1'b1, 1'b0, 20'h01000, 20'h02000, 16'h0002);
        pulse();
        wait_wr();
        check(l_addr, 20'h02000);
        check(l_data, mem(20'h01000));
        pulse();
        wait_wr();
        check(l_addr, 20'h02002);
        check(l_data, mem(20'h01002));
        wait_done();
        check(done, 1'b1);
        @(negedge ref_clk);
        check(left, 16'h0002);
        pulse();
        wait_wr();
        check(l_addr, 20'h02000);
        check(l_data, mem(20'h01000));
        cfg(1'b1, 1'b0, 20'h01030, 20'h02200, 16'h0001);
        pulse();
        en <= 1'b0;
        wait_done();
        @(negedge ref_clk);
        @(negedge ref_clk);
        check(left, 16'h0000);
        $display("repeat test finished");
    endtask : t_repeat
    task automatic t_burst();
        int slots, low, g;
        cfg(1'b1, 1'b1, 20'h01100, 20'h03000, 16'h0004);
        halt <= 1'b1;
        pulse();
        repeat (20) @(negedge ref_clk);
        slots = 0;
        low = 0;
        g = 0;
        repeat (100) begin
            @(negedge ref_clk);
            slots += slot;
            low += !req;
            g += grant;
        end
        check(slots >= 18 && slots <= 22, 1'b1);
        check(low, 0);
        check(g, 0);
        @(posedge ref_clk);
        en <= 1'b0;
        cpu_req <= 1'b1;
        g = 0;
        repeat (40) begin
            @(negedge ref_clk);
            g += grant;
        end
        check(g, 0);
        @(posedge ref_clk);
        cpu_req <= 1'b0;
        g = 0;
        while (grant !== 1'b1 && g < 20) begin
            @(negedge ref_clk);
            g++;
        end
        check(grant, 1'b1);
        check(g <= 2, 1'b1);
        @(posedge ref_clk);
        halt <= 1'b0;
        $display("burst test finished");
    endtask : t_burst
    task automatic t_flags();
        cfg(1'b0, 1'b0, 20'h01010, DBS_FLAG_ADDR, 16'h0001);
        waits <= 4'h2;
        flags <= 8'h81;
        pulse();
        wait_wr();
        check(l_addr, DBS_FLAG_ADDR);
        check(l_data, mem(20'h01010) | 16'h0081);
        $display("flag test finished");
    endtask : t_flags
    task automatic t_hold();
        int busy;
        cfg(1'b0, 1'b0, 20'h01020, 20'h02100, 16'h0001);
        blk <= 1'b1;
        rmw <= 1'b1;
        pulse();
        busy = 0;
        repeat (20) begin
            @(negedge ref_clk);
            busy += rd | wr;
        end
        check(busy, 0);
        @(posedge ref_clk);
        rmw <= 1'b0;
        wait_wr();
        check(l_addr, 20'h02100);
        check(l_data, mem(20'h01020));
        $display("hold test finished");
    endtask : t_hold
    initial begin
        rst = 1'b1;
        {en, rep, bst, blk, rmw, trig, cpu_req, halt} = 8'h00;
        src = 20'h00000;
        dst = 20'h00000;
        size = 16'h0000;
        flags = 8'h00;
        waits = 4'h0;
        bad_count = 0;
        checks_done = 0;
        cyc = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check({rd, wr, req, slot, grant, done}, 6'h00);
        check(left, 16'h0000);
        t_repeat();
        t_burst();
        t_flags();
        t_hold();
        test_done();
    end
endmodule : dbs_dma_engine_tb
`default_nettype wire
